// ===== rtl/swp_pkg.sv
// Package of constants and types for the write-protection block
package swp_pkg;

  // Instruction encodings
  localparam logic [7:0] SWP_CMD_SET_LATCH   = 8'h06;
  localparam logic [7:0] SWP_CMD_CLEAR_LATCH = 8'h04;
  localparam logic [7:0] SWP_CMD_READ_STATUS = 8'h05;
  localparam logic [7:0] SWP_CMD_WRITE_STAT  = 8'h01;
  localparam logic [7:0] SWP_CMD_READ_ARRAY  = 8'h03;
  localparam logic [7:0] SWP_CMD_WRITE_ARRAY = 8'h02;

  // Status register field positions
  localparam int SWP_BIT_HW_EN   = 7;
  localparam int SWP_BIT_BP_HIGH = 3;
  localparam int SWP_BIT_BP_LOW  = 2;
  localparam int SWP_BIT_LATCH   = 1;
  localparam int SWP_BIT_BUSY    = 0;

  // Nonvolatile reset values
  localparam logic [1:0] SWP_BP_RESET    = 2'h0;
  localparam logic       SWP_HW_EN_RESET = 1'b0;

  // Protected-range bounds (14-bit array address)
  localparam logic [13:0] SWP_QUARTER_BASE = 14'h3000;
  localparam logic [13:0] SWP_HALF_BASE    = 14'h2000;

  // Self-timed write cycle
  localparam int SWP_WRITE_TIME_US = 5000;
  localparam int SWP_CLK_MHZ       = 50;
  localparam int SWP_WRITE_CYCLES  = SWP_WRITE_TIME_US * SWP_CLK_MHZ;

  // Bit counter end value
  localparam logic [2:0] SWP_BIT_LAST = 3'h7;

  // Serial pin group
  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } swp_pins_s;

  // Decoded serial event from the shifter
  typedef struct packed {
    logic       byte_done;
    logic [7:0] data;
    logic       fall;
    logic       select;
    logic       deselect;
  } swp_evt_s;

endpackage

// ===== rtl/swp_sync.sv
// Two-flop synchroniser for the serial pins
module swp_sync (
  // Clock and reset
  input  wire logic           clk,
  input  wire logic           nrst,
  // Pins
  input  wire swp_pkg::swp_pins_s pins_in,
  output      swp_pkg::swp_pins_s pins_out
);
  import swp_pkg::*;

  swp_pins_s stage1;
  swp_pins_s stage2;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stage1 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
      stage2 <= '{cs_n: 1'b1, sck: 1'b0, si: 1'b0};
    end else begin
      stage1 <= pins_in;
      stage2 <= stage1;
    end
  end

  assign pins_out = stage2;

endmodule

// ===== rtl/swp_shift.sv
// Serial shifter: edge detection and byte assembly, MSB first
module swp_shift (
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               nrst,
  // Synchronised pins
  input  wire swp_pkg::swp_pins_s pins,
  // Decoded events
  output      swp_pkg::swp_evt_s  evt
);
  import swp_pkg::*;

  logic       sck_q;
  logic       cs_q;
  logic [2:0] bit_cnt;
  logic [7:0] shreg;
  logic       rise;

  assign rise = pins.sck & ~sck_q & ~pins.cs_n;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sck_q <= 1'b0;
      cs_q  <= 1'b1;
    end else begin
      sck_q <= pins.sck;
      cs_q  <= pins.cs_n;
    end
  end

  // Sample on rising SCK, MSB first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bit_cnt <= 3'h0;
      shreg   <= 8'h00;
    end else if (pins.cs_n) begin
      bit_cnt <= 3'h0;
    end else if (rise) begin
      shreg   <= {shreg[6:0], pins.si};
      bit_cnt <= bit_cnt + 3'h1;
    end
  end

  assign evt.byte_done = rise & (bit_cnt == SWP_BIT_LAST);
  assign evt.data      = {shreg[6:0], pins.si};
  assign evt.fall      = ~pins.sck & sck_q & ~pins.cs_n;
  assign evt.select    = ~pins.cs_n & cs_q;
  assign evt.deselect  = pins.cs_n & ~cs_q;

endmodule

// ===== rtl/swp_top.sv
// Write-protection and status logic of a serial EEPROM
// What this block does
// - Internal write completes only if the write latch was set beforehand
// - Set-latch instruction sets the latch, clear-latch clears it
// - Latch cleared at power-up and after clear, accepted status write, accepted array write
// - Status read is answered at any time, even while busy
// - Status: bit7 protect enable, bits3-2 block protect, bit1 latch, bit0 busy
// - Busy flag is 1 during an internal write; writes to it are ignored
// - Latch flag mirrors the write latch, read-only
// - Latch instructions work even while the status register is protected
// - Block-protect bits are nonvolatile, changed only by status write; here nrst also clears them to 00
// - Block protect 00 none, 01 3000h up, 10 2000h up, 11 all
// - Hardware protection active while pin low and enable bit set
// - Hardware protection blocks status writes only, not array or latch
// - Status write instruction updates protect enable and block bits
// - Array access during an internal write is ignored
// - Power-up: standby, latch clear, serial output undriven
// - Device stays inactive until a falling chip-select edge
// - Encodings: 06 set, 04 clear, 05 status read, 01 status write
// - Latch set only at chip-select rise after the set instruction
// - MSB first; sample on rising clock, change output after falling
module swp_top #(
  parameter int WRITE_CYCLES = swp_pkg::SWP_WRITE_CYCLES
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic nrst,
  // Serial bus
  input  wire logic cs_n,
  input  wire logic sck,
  input  wire logic si,
  output      logic so_o,
  output      logic so_oe,
  // Write-protect pin
  input  wire logic wp_n,
  // Observation of state
  output      logic [7:0] protection_status,
  output      logic       array_write_strobe,
  output      logic [13:0] array_write_addr
);
  import swp_pkg::*;

  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_CMD   = 6'b000010,
    ST_ADDR  = 6'b000100,
    ST_DATA  = 6'b001000,
    ST_STAT  = 6'b010000,
    ST_SKIP  = 6'b100000
  } swp_state_e;

  swp_pins_s  pins_raw;
  swp_pins_s  pins;
  swp_evt_s   evt;
  logic       wp_s1;
  logic       wp_s2;
  swp_state_e state;
  logic [7:0] cmd;
  logic [1:0] addr_bytes;
  logic [15:0] addr;
  logic       frame_ok;
  logic       pend_ok;
  logic       armed;
  logic       write_latch_flag;
  logic       write_busy_flag;
  logic       block_protect_high;
  logic       block_protect_low;
  logic       hw_protect_enable;
  logic [7:0] new_status;
  logic [7:0] out_sr;
  logic [31:0] busy_cnt;
  logic       hw_active;
  logic       write_go;
  logic [1:0] sync_fill;
  logic       sck_prev;
  logic       sck_rise;

  // Block-protection decode, used for every array write
  function automatic logic addr_protected(input logic [1:0] bp,
                                          input logic [13:0] a);
    unique case (bp)
      2'h0: addr_protected = 1'b0;
      2'h1: addr_protected = (a >= SWP_QUARTER_BASE);
      2'h2: addr_protected = (a >= SWP_HALF_BASE);
      2'h3: addr_protected = 1'b1;
    endcase
  endfunction

  assign pins_raw = '{cs_n: cs_n, sck: sck, si: si};

  swp_sync u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .pins_in  (pins_raw),
    .pins_out (pins)
  );

  swp_shift u_shift (
    .clk  (clk),
    .nrst (nrst),
    .pins (pins),
    .evt  (evt)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wp_s1    <= 1'b1;
      wp_s2    <= 1'b1;
      sck_prev <= 1'b0;
    end else begin
      wp_s1    <= wp_n;
      wp_s2    <= wp_s1;
      sck_prev <= pins.sck;
    end
  end

  assign hw_active = ~wp_s2 & hw_protect_enable;
  // Clock rise inside a frame; one that closes no byte spoils it
  assign sck_rise  = pins.sck & ~sck_prev & ~pins.cs_n;

  // Arm once cs_n is truly seen high, so a frame open at reset is skipped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sync_fill <= 2'h0;
      armed     <= 1'b0;
    end else begin
      sync_fill <= {sync_fill[0], 1'b1};
      if (sync_fill[1] && pins.cs_n) begin
        armed <= 1'b1;
      end
    end
  end

  // Instruction sequencer
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state      <= ST_IDLE;
      cmd        <= 8'h00;
      addr_bytes <= 2'h0;
      addr       <= 16'h0000;
      frame_ok   <= 1'b0;
      new_status <= 8'h00;
    end else if (pins.cs_n) begin
      state <= ST_IDLE;
    end else if (evt.select && armed) begin
      state    <= ST_CMD;
      frame_ok <= 1'b0;
    end else if (evt.select) begin
      state <= ST_SKIP;
    end else if (evt.byte_done) begin
      unique case (state)
        ST_CMD: begin
          cmd      <= evt.data;
          frame_ok <= 1'b1;
          addr_bytes <= 2'h0;
          if (evt.data == SWP_CMD_WRITE_ARRAY ||
              evt.data == SWP_CMD_READ_ARRAY) begin
            state    <= ST_ADDR;
            frame_ok <= 1'b0;
          end else if (evt.data == SWP_CMD_WRITE_STAT) begin
            state    <= ST_DATA;
            frame_ok <= 1'b0;
          end else if (evt.data == SWP_CMD_READ_STATUS) begin
            state <= ST_STAT;
          end else begin
            state <= ST_SKIP;
          end
        end
        ST_ADDR: begin
          addr       <= {addr[7:0], evt.data};
          addr_bytes <= addr_bytes + 2'h1;
          if (addr_bytes == 2'h1) begin
            state <= ST_DATA;
          end
        end
        ST_DATA: begin
          frame_ok   <= 1'b1;
          new_status <= evt.data;
        end
        ST_STAT, ST_SKIP, ST_IDLE: begin
          state <= state;
        end
      endcase
    end else if (sck_rise) begin
      frame_ok <= 1'b0;
    end
  end

  // A write counts only when the last clock closed a whole byte
  assign pend_ok = frame_ok && (cmd != SWP_CMD_READ_ARRAY);

  // Accepted write: whole frame, latch set, idle, target not protected
  assign write_go = evt.deselect && state == ST_DATA && pend_ok &&
                    write_latch_flag && !write_busy_flag &&
                    ((cmd == SWP_CMD_WRITE_STAT && !hw_active) ||
                     (cmd == SWP_CMD_WRITE_ARRAY &&
                      !addr_protected({block_protect_high,
                                       block_protect_low},
                                      addr[13:0])));

  // Write latch
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      write_latch_flag <= 1'b0;
    end else if (evt.deselect && state == ST_SKIP && frame_ok) begin
      if (cmd == SWP_CMD_SET_LATCH) begin
        write_latch_flag <= 1'b1;
      end else if (cmd == SWP_CMD_CLEAR_LATCH) begin
        write_latch_flag <= 1'b0;
      end
    end else if (write_go) begin
      write_latch_flag <= 1'b0;
    end
  end

  // Nonvolatile status bits and array write strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      block_protect_high <= SWP_BP_RESET[1];
      block_protect_low  <= SWP_BP_RESET[0];
      hw_protect_enable  <= SWP_HW_EN_RESET;
      array_write_strobe <= 1'b0;
      array_write_addr   <= 14'h0000;
    end else begin
      array_write_strobe <= 1'b0;
      if (write_go && cmd == SWP_CMD_WRITE_STAT) begin
        hw_protect_enable  <= new_status[SWP_BIT_HW_EN];
        block_protect_high <= new_status[SWP_BIT_BP_HIGH];
        block_protect_low  <= new_status[SWP_BIT_BP_LOW];
      end else if (write_go) begin
        array_write_strobe <= 1'b1;
        array_write_addr   <= addr[13:0];
      end
    end
  end

  // Self-timed write cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      write_busy_flag <= 1'b0;
      busy_cnt        <= 32'h0;
    end else if (write_go) begin
      write_busy_flag <= 1'b1;
      busy_cnt        <= 32'(WRITE_CYCLES - 1);
    end else if (write_busy_flag) begin
      if (busy_cnt == 32'h0) begin
        write_busy_flag <= 1'b0;
      end else begin
        busy_cnt <= busy_cnt - 32'h1;
      end
    end
  end

  // Status image with unused bits zero
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      protection_status <= 8'h00;
    end else begin
      protection_status <= {hw_protect_enable, 3'h0, block_protect_high,
                            block_protect_low, write_latch_flag,
                            write_busy_flag};
    end
  end

  // Serial output, changed after falling SCK
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      so_o   <= 1'b0;
      so_oe  <= 1'b0;
      out_sr <= 8'h00;
    end else if (pins.cs_n) begin
      so_oe <= 1'b0;
    end else if (state == ST_CMD && evt.byte_done &&
                 evt.data == SWP_CMD_READ_STATUS) begin
      out_sr <= protection_status;
    end else if (state == ST_STAT && evt.fall) begin
      so_oe  <= 1'b1;
      so_o   <= out_sr[7];
      out_sr <= {out_sr[6:0], protection_status[0]};
    end
  end

  AST_LATCH_SET: assert property (@(posedge clk) disable iff (!nrst)
    (evt.deselect && state == ST_SKIP && frame_ok &&
     cmd == SWP_CMD_SET_LATCH) |=> write_latch_flag)
    else $error("latch not set after set instruction");
  AST_LATCH_CLR: assert property (@(posedge clk) disable iff (!nrst)
    (evt.deselect && state == ST_SKIP && frame_ok &&
     cmd == SWP_CMD_CLEAR_LATCH) |=> !write_latch_flag)
    else $error("latch not cleared");
  AST_NO_LATCH_NO_WRITE: assert property (
    @(posedge clk) disable iff (!nrst)
    (!write_latch_flag && !write_busy_flag) |=> !$rose(write_busy_flag))
    else $error("write started without latch");
  AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (!nrst)
    $rose(write_busy_flag) |-> write_busy_flag [*8])
    else $error("busy dropped too early");
  AST_STATUS_MAP: assert property (@(posedge clk) disable iff (!nrst)
    ##1 protection_status == {$past(hw_protect_enable), 3'h0,
      $past(block_protect_high), $past(block_protect_low),
      $past(write_latch_flag), $past(write_busy_flag)})
    else $error("status layout wrong");
  AST_HW_LOCK: assert property (@(posedge clk) disable iff (!nrst)
    hw_active |=> $stable({hw_protect_enable, block_protect_high,
                           block_protect_low}))
    else $error("protected status bits changed");
  AST_PROT_ALL: assert property (@(posedge clk) disable iff (!nrst)
    (block_protect_high && block_protect_low) |=> !array_write_strobe)
    else $error("write into protected array");
  AST_ARMED: assert property (@(posedge clk) disable iff (!nrst)
    !armed |-> !so_oe)
    else $error("output driven before first select");
  AST_NO_WRITE_BUSY: assert property (
    @(posedge clk) disable iff (!nrst)
    write_busy_flag |=> !$rose(array_write_strobe))
    else $error("array write during busy cycle");

endmodule

// ===== test/swp_host.sv
// Host master model that drives the serial pins of the block
module swp_host (
  // Clock
  input  wire logic clk,
  // Serial pins
  output      logic cs_n,
  output      logic sck,
  output      logic si,
  input  wire logic so_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end

  // One frame, MSB first; the last 8 bits seen on so end up in rd
  task automatic xfer(input logic [63:0] d, input int nbits,
                      output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk);
    #1 cs_n = 1'b0;
    repeat (4) @(posedge clk);
    for (int i = nbits - 1; i >= 0; i--) begin
      #1 sck = 1'b0;
      si = d[i];
      repeat (4) @(posedge clk);
      #1 sck = 1'b1;
      repeat (4) @(posedge clk);
      // Sampled late in the high phase to cover sync lag
      rd = {rd[6:0], so_o};
    end
    #1 sck = 1'b0;
    si = ~si;
    repeat (4) @(posedge clk);
    #1 cs_n = 1'b1;
    repeat (8) @(posedge clk);
  endtask
endmodule

// ===== test/tb_top.sv
// Self-checking bench for the write-protection block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import swp_pkg::*;

  typedef struct packed {
    logic [1:0]  bp;
    logic [15:0] addr;
    logic        ok;
  } swp_row_s;

  logic        clk;
  logic        nrst;
  logic        wp_n;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        so_o;
  logic        so_oe;
  logic [7:0]  protection_status;
  logic        array_write_strobe;
  logic [13:0] array_write_addr;
  logic [7:0]  rd;
  logic [13:0] last_addr;
  int          n_fail;
  int          cmp_count;
  int          n_strobe;
  int          n_oe = 0;
  int          s0;
  swp_row_s    rows [7] = '{
    '{2'h0, 16'hffff, 1'b1}, '{2'h0, 16'h3000, 1'b1},
    '{2'h1, 16'h2fff, 1'b1}, '{2'h1, 16'h3000, 1'b0},
    '{2'h2, 16'h1fff, 1'b1}, '{2'h2, 16'h2000, 1'b0},
    '{2'h3, 16'h0000, 1'b0}};

  swp_top #(.WRITE_CYCLES(600)) i_swp_top (
    .clk(clk), .nrst(nrst), .cs_n(cs_n), .sck(sck), .si(si),
    .so_o(so_o), .so_oe(so_oe), .wp_n(wp_n),
    .protection_status(protection_status),
    .array_write_strobe(array_write_strobe),
    .array_write_addr(array_write_addr));

  swp_host i_swp_host (
    .clk(clk), .cs_n(cs_n), .sck(sck), .si(si), .so_o(so_o));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial n_strobe = 0;
  always @(posedge clk) begin
    if (so_oe === 1'b1)
      n_oe++;
    if (array_write_strobe === 1'b1) begin
      n_strobe++;
      last_addr = array_write_addr;
    end
  end

  task automatic check(input string nm, input logic [15:0] seen, exp);
    #2;
    cmp_count++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      n_fail++;
    end
  endtask

  task automatic cmd(input logic [7:0] c);
    i_swp_host.xfer({56'h0, c}, 8, rd);
  endtask

  task automatic wr_stat(input logic [7:0] v);
    i_swp_host.xfer({48'h0, SWP_CMD_WRITE_STAT, v}, 16, rd);
  endtask

  task automatic wr_arr(input logic [15:0] a);
    i_swp_host.xfer({24'h0, SWP_CMD_WRITE_ARRAY, a, 8'h5a}, 32, rd);
  endtask

  task automatic rd_stat;
    i_swp_host.xfer({48'h0, SWP_CMD_READ_STATUS, 8'h00}, 16, rd);
  endtask

  task automatic wait_idle;
    for (int k = 0; k < 1000 && protection_status[0] !== 1'b0; k++)
      @(posedge clk);
    if (protection_status[0] !== 1'b0) begin
      n_fail++;
      report_and_stop();
    end else begin
      repeat (2) @(posedge clk);
    end
  endtask

  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    n_fail = 0;
    cmp_count = 0;
    nrst = 1'b0;
    wp_n = 1'b1;
    repeat (8) @(posedge clk);
    #1 nrst = 1'b1;
    check("status_por", protection_status, 8'h00);
    check("so_oe_por", so_oe, 1'b0);
    foreach (rows[i]) begin
      cmd(SWP_CMD_SET_LATCH);
      wr_stat({4'h0, rows[i].bp, 2'h0});
      wait_idle();
      check("bp", protection_status, {4'h0, rows[i].bp, 2'h0});
      cmd(SWP_CMD_SET_LATCH);
      s0 = n_strobe;
      wr_arr(rows[i].addr);
      check("strobe", 16'(n_strobe - s0), 16'(rows[i].ok));
      if (rows[i].ok)
        check("addr", last_addr, rows[i].addr[13:0]);
      wait_idle();
      check("latch", protection_status[1], !rows[i].ok);
    end
    // Mid-run reset with latch and protect bits set
    @(posedge clk);
    #1 nrst = 1'b0;
    repeat (2) @(posedge clk);
    check("so_oe_rst", so_oe, 1'b0);
    check("status_rst", protection_status, 8'h00);
    #1 nrst = 1'b1;
    cmd(SWP_CMD_SET_LATCH);
    check("latch_set", protection_status, 8'h02);
    cmd(SWP_CMD_CLEAR_LATCH);
    check("latch_clr", protection_status, 8'h00);
    s0 = n_strobe;
    i_swp_host.xfer({24'h0, SWP_CMD_SET_LATCH, SWP_CMD_WRITE_ARRAY,
                     16'h0000, 8'h5a}, 40, rd);
    check("same_frame", protection_status, 8'h00);
    wr_arr(16'h0000);
    check("no_latch", 16'(n_strobe - s0), 16'h0);
    // Array access while a write is in progress
    cmd(SWP_CMD_SET_LATCH);
    wr_arr(16'h0000);
    check("busy", protection_status[0], 1'b1);
    cmd(SWP_CMD_SET_LATCH);
    wr_arr(16'h0100);
    check("busy_ign", 16'(n_strobe - s0), 16'h1);
    check("busy_addr", last_addr, 14'h0000);
    wait_idle();
    cmd(SWP_CMD_CLEAR_LATCH);
    // Write frame cut one bit short
    cmd(SWP_CMD_SET_LATCH);
    i_swp_host.xfer({33'h0, SWP_CMD_WRITE_ARRAY, 16'h0040, 7'h55}, 31, rd);
    check("partial", 16'(n_strobe - s0), 16'h1);
    check("partial_st", protection_status, 8'h02);
    // Hardware protection
    wr_stat(8'h80);
    wait_idle();
    check("hw_en", protection_status, 8'h80);
    @(posedge clk);
    #1 wp_n = 1'b0;
    cmd(SWP_CMD_SET_LATCH);
    wr_stat(8'h0c);
    check("hw_block", protection_status, 8'h82);
    wr_arr(16'h0200);
    check("hw_arr", 16'(n_strobe - s0), 16'h2);
    wait_idle();
    cmd(SWP_CMD_SET_LATCH);
    check("hw_latch", protection_status, 8'h82);
    cmd(SWP_CMD_CLEAR_LATCH);
    check("hw_unlatch", protection_status, 8'h80);
    @(posedge clk);
    #1 wp_n = 1'b1;
    cmd(SWP_CMD_SET_LATCH);
    wr_stat(8'h00);
    wait_idle();
    check("hw_off", protection_status, 8'h00);
    // Status write with read-only and unused bits set
    cmd(SWP_CMD_SET_LATCH);
    wr_stat(8'h7f);
    rd_stat();
    check("rd_busy", rd & 8'hf1, 8'h01);
    wait_idle();
    check("junk", protection_status, 8'h0c);
    rd_stat();
    check("rd_idle", rd, 8'h0c);
    check("so_oe_on", 16'(n_oe != 0), 16'h1);
    check("so_oe_off", so_oe, 1'b0);
    report_and_stop();
  end
endmodule
